//--- hw/adcsq_top.sv
// converter sequencing, sync trigger phase reset and output word control
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module adcsq_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_sync_trigger,
    input wire logic [adcsq_pkg::NUM_CONV*adcsq_pkg::RAW_W-1:0] i_conversion_word,
    input wire logic [adcsq_pkg::ADDR_W-1:0] i_addr,
    input wire logic [adcsq_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [adcsq_pkg::DATA_W-1:0] o_rd_data,
    output logic o_conv_strobe,
    output logic o_odd_sample,
    output logic [adcsq_pkg::NUM_CONV*adcsq_pkg::SEL_W-1:0] o_input_select,
    output logic [3:0] o_frame_phase,
    output logic [adcsq_pkg::WORD_W-1:0] o_test_pattern,
    output logic o_data_invalid,
    output logic [adcsq_pkg::NUM_CONV*adcsq_pkg::WORD_W-1:0] o_processed_word,
    output logic [adcsq_pkg::NUM_CONV-1:0] o_word_valid
);
    import adcsq_pkg::*;

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync;
        logic trig_lvl;
        logic div;
        logic strobe;
        logic odd;
        logic [3:0] frame;
        logic [WORD_W-1:0] pattern;
        logic [2:0] inval_cnt;
        logic inval;
        logic seen;
        logic [CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] rdata;
        logic [NUM_CONV*SEL_W-1:0] sel;
    } adcsq_top_s;

    adcsq_top_s q;
    adcsq_top_s d;

    logic [1:0] mode;
    logic [1:0] res_eff;
    logic bypass;
    logic masked;
    logic trig_agree;
    logic sync_event;
    logic phase_reset;
    logic [DATA_W-1:0] status;
    logic [NUM_CONV-1:0] lane_valid;

    //------------------------------------------------------------
    // control decode
    //------------------------------------------------------------
    assign mode = q.ctrl[CTRL_MODE_LSB +: 2];
    assign bypass = q.ctrl[CTRL_BYPASS];
    assign masked = q.ctrl[CTRL_MASK];

    always_comb begin
        // the 8-input mode only runs at the lowest resolution
        if (mode == MODE_8) begin
            res_eff = RES_10;
        end else if (q.ctrl[CTRL_RES_LSB +: 2] == RES_12) begin
            res_eff = RES_12;
        end else if (q.ctrl[CTRL_RES_LSB +: 2] == RES_14) begin
            res_eff = RES_14;
        end else begin
            res_eff = RES_10;
        end
    end

    //------------------------------------------------------------
    // trigger detection
    //------------------------------------------------------------
    // stage 0 only feeds stage 1; the level moves once stages 1 and 2 agree
    assign trig_agree = (q.sync[1] == q.sync[2]);
    assign sync_event = trig_agree && q.sync[2] && !q.trig_lvl;
    assign phase_reset = sync_event && !masked;

    always_comb begin
        status = '0;
        status[STAT_SEEN] = q.seen;
        status[STAT_INVAL] = q.inval;
        status[STAT_DIV] = q.div;
        status[STAT_ODD] = q.odd;
        status[STAT_FRAME_LSB +: 4] = q.frame;
    end

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync = {q.sync[1:0], i_sync_trigger};
        if (trig_agree) begin
            d.trig_lvl = q.sync[2];
        end

        // conversion clock: full rate, or system clock halved in 8-input mode
        if (phase_reset) begin
            d.div = 1'b0;
        end else if (mode == MODE_8) begin
            d.div = !q.div;
        end else begin
            d.div = 1'b0;
        end
        d.strobe = (mode != MODE_8) || !d.div;

        // sampling circuit phase: odd first after a reset, then alternate
        if (phase_reset) begin
            d.odd = 1'b1;
        end else if (d.strobe) begin
            d.odd = !q.odd;
        end

        // frame clock phase and test pattern both restart on the trigger
        if (phase_reset) begin
            d.frame = '0;
            d.pattern = '0;
        end else begin
            if (d.strobe) begin
                d.frame = (q.frame == FRAME_WRAP) ? 4'h0 : q.frame + 4'h1;
            end
            d.pattern = q.pattern + 16'h0001;
        end

        // output data flagged bad for the worst case after a phase reset
        if (phase_reset) begin
            d.inval_cnt = INVALID_CLKS;
            d.inval = 1'b1;
        end else if (q.inval_cnt != 3'h0) begin
            d.inval_cnt = q.inval_cnt - 3'h1;
            d.inval = (q.inval_cnt != 3'h1);
        end else begin
            d.inval = 1'b0;
        end

        // input selection for each converter in the sample just coming
        for (int k = 0; k < NUM_CONV; k++) begin
            if (mode == MODE_32) begin
                d.sel[k*SEL_W +: SEL_W] = d.odd ? SEL_W'(2*k) : SEL_W'(2*k+1);
            end else if (mode == MODE_8) begin
                d.sel[k*SEL_W +: SEL_W] = SEL_W'(k/2);
            end else begin
                d.sel[k*SEL_W +: SEL_W] = SEL_W'(k);
            end
        end

        // register port; a new trigger beats a clear in the same cycle
        d.rdata = '0;
        if (i_wr && i_addr == ADDR_CTRL) begin
            d.ctrl = i_wr_data[CTRL_W-1:0];
        end else if (i_wr && i_addr == ADDR_STATUS && i_wr_data[STAT_SEEN]) begin
            d.seen = 1'b0;
        end
        if (sync_event) begin
            d.seen = 1'b1;
        end
        if (i_rd && i_addr == ADDR_CTRL) begin
            d.rdata = {{(DATA_W-CTRL_W){1'b0}}, q.ctrl};
        end else if (i_rd && i_addr == ADDR_STATUS) begin
            d.rdata = status;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    //------------------------------------------------------------
    // converter lanes
    //------------------------------------------------------------
    for (genvar g = 0; g < NUM_CONV; g++) begin : g_lane
        adcsq_format u_fmt (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_clk_en(i_clk_en),
            .i_valid(q.strobe),
            .i_raw(i_conversion_word[g*RAW_W +: RAW_W]),
            .i_res(res_eff),
            .i_bypass(bypass),
            .o_word(o_processed_word[g*WORD_W +: WORD_W]),
            .o_valid(lane_valid[g])
        );
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign o_rd_data = q.rdata;
    assign o_conv_strobe = q.strobe;
    assign o_odd_sample = q.odd;
    assign o_input_select = q.sel;
    assign o_frame_phase = q.frame;
    assign o_test_pattern = q.pattern;
    assign o_data_invalid = q.inval;
    assign o_word_valid = lane_valid;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_reset_seen;
        i_clk_en && phase_reset;
    endsequence

    // six enabled clocks with no fresh reset: the length of the bad-data window
    sequence s_invalid_run;
        (i_clk_en && !phase_reset) [*6];
    endsequence

    property p_half_rate;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && mode == MODE_8 && !phase_reset && o_conv_strobe ##1 i_clk_en && mode == MODE_8 && !phase_reset)
        |-> !o_conv_strobe ##1 o_conv_strobe;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("conversion clock not halved");

    property p_full_rate;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && mode != MODE_8) |=> o_conv_strobe;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("conversion clock not full rate");

    property p_phase_reset;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_reset_seen |=> (o_odd_sample && o_conv_strobe && o_frame_phase == 4'h0 && o_test_pattern == 16'h0000);
    endproperty
    a_phase_reset: assert property (p_phase_reset) else $error("phases not reset by trigger");

    property p_invalid_window;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_reset_seen ##1 s_invalid_run) |-> o_data_invalid && $past(o_data_invalid, 5);
    endproperty
    a_invalid_window: assert property (p_invalid_window) else $error("invalid window too short");

    property p_invalid_ends;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s_reset_seen ##1 (i_clk_en && !phase_reset) [*7]) |-> !o_data_invalid;
    endproperty
    a_invalid_ends: assert property (p_invalid_ends) else $error("invalid window too long");

    property p_masked;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && sync_event && masked && !o_data_invalid) |=> !o_data_invalid;
    endproperty
    a_masked: assert property (p_masked) else $error("masked trigger reset phase");

    property p_even_follows;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && mode == MODE_32 && !phase_reset && o_odd_sample ##1 i_clk_en && !phase_reset && mode == MODE_32)
        |-> (!o_odd_sample && o_input_select[SEL_W-1:0] == 5'h01)
        ##1 (o_odd_sample && o_input_select[SEL_W-1:0] == 5'h00);
    endproperty
    a_even_follows: assert property (p_even_follows) else $error("even sample not one clock late");

    property p_map16;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && mode == MODE_16) |=> (o_input_select[2*SEL_W-1:SEL_W] == 5'h01);
    endproperty
    a_map16: assert property (p_map16) else $error("16-input mapping wrong");

    property p_one_event;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && sync_event) |=> !sync_event;
    endproperty
    a_one_event: assert property (p_one_event) else $error("trigger gave two events");

    property p_read_slot;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && !i_rd) |=> (o_rd_data == 32'h0000_0000);
    endproperty
    a_read_slot: assert property (p_read_slot) else $error("read data outside its slot");

    property p_seen_sticky;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && sync_event) |=> q.seen;
    endproperty
    a_seen_sticky: assert property (p_seen_sticky) else $error("trigger seen flag lost");
endmodule

//--- common/adcsq_pkg.sv
// constants shared by the converter sequencing and sync control block
//------------------------------------------------------------
//------------------------------------------------------------
package adcsq_pkg;
    localparam int unsigned NUM_CONV = 16;
    localparam int unsigned RAW_W = 14;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PROC_STAGES = 2;
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // control fields
    localparam int unsigned CTRL_W = 7;
    localparam int unsigned CTRL_RES_LSB = 0;
    localparam int unsigned CTRL_MODE_LSB = 2;
    localparam int unsigned CTRL_BYPASS = 4;
    localparam int unsigned CTRL_MASK = 5;
    localparam int unsigned CTRL_PAT_EN = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // status fields
    localparam int unsigned STAT_SEEN = 0;
    localparam int unsigned STAT_INVAL = 1;
    localparam int unsigned STAT_DIV = 2;
    localparam int unsigned STAT_ODD = 3;
    localparam int unsigned STAT_FRAME_LSB = 4;
    // resolution codes
    localparam logic [1:0] RES_10 = 2'h0;
    localparam logic [1:0] RES_12 = 2'h1;
    localparam logic [1:0] RES_14 = 2'h2;
    // input mode codes
    localparam logic [1:0] MODE_16 = 2'h0;
    localparam logic [1:0] MODE_32 = 2'h1;
    localparam logic [1:0] MODE_8 = 2'h2;
    // timing counts: invalid window in system clocks, frame wrap in conversion strobes
    localparam logic [2:0] INVALID_CLKS = 3'h6;
    localparam logic [3:0] FRAME_WRAP = 4'hF;
endpackage

//--- hw/adcsq_format.sv
// one converter lane: left-aligns a raw result and runs bypass or processing path
`timescale 1ns/1ps
module adcsq_format (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_valid,
    input wire logic [adcsq_pkg::RAW_W-1:0] i_raw,
    input wire logic [1:0] i_res,
    input wire logic i_bypass,
    output logic [adcsq_pkg::WORD_W-1:0] o_word,
    output logic o_valid
);
    import adcsq_pkg::*;

    typedef struct packed {
        logic [PROC_STAGES-1:0] vld;
        logic [PROC_STAGES-1:0][WORD_W-1:0] pipe;
        logic [WORD_W-1:0] word;
        logic valid;
    } adcsq_lane_s;

    adcsq_lane_s q;
    adcsq_lane_s d;
    logic [WORD_W-1:0] aligned;

    always_comb begin
        // raw result sits in the low bits at the chosen width
        case (i_res)
            RES_12: aligned = {i_raw[11:0], 4'h0};
            RES_14: aligned = {i_raw[13:0], 2'h0};
            default: aligned = {i_raw[9:0], 6'h00};
        endcase
        d = q;
        d.vld = {q.vld[PROC_STAGES-2:0], i_valid};
        d.pipe = {q.pipe[PROC_STAGES-2:0], aligned};
        if (i_bypass) begin
            // same cycle as the capture: no stage beyond the output flop
            d.word = aligned;
            d.valid = i_valid;
        end else begin
            d.word = q.pipe[PROC_STAGES-1];
            d.valid = q.vld[PROC_STAGES-1];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_word = q.word;
    assign o_valid = q.valid;

    property p_bypass_latency;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && i_bypass && i_valid) |=> o_valid;
    endproperty
    a_bypass_latency: assert property (p_bypass_latency) else $error("bypass added latency");

    property p_low_zero;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_clk_en && i_bypass && i_res == RES_10) |=> (o_word[5:0] == 6'h00);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("unused low bits not zero");
endmodule

//--- testbench/adcsq_host_model.sv
// host side model: pulses the sync trigger and counts usable output words
`timescale 1ns/1ps
module adcsq_host_model (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_fire,
    input wire logic i_data_invalid,
    input wire logic i_word_valid,
    output logic o_sync_trigger,
    output logic [15:0] o_good_count
);
    logic [2:0] gap_q;
    logic armed_q;
    // pin high three clocks then low at least four, so the device sees one clean rise
    assign o_sync_trigger = gap_q > 3'h4;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_q <= 3'h0;
            armed_q <= 1'b0;
            o_good_count <= 16'h0;
        end else begin
            if (i_fire && gap_q == 3'h0) begin
                gap_q <= 3'h7;
            end else if (gap_q != 3'h0) begin
                gap_q <= gap_q - 3'h1;
            end
            if (o_sync_trigger) begin
                armed_q <= 1'b1;
            end
            // words inside the invalid window are dropped, not trusted
            if (armed_q && i_word_valid && !i_data_invalid) begin
                o_good_count <= o_good_count + 16'h1;
            end
        end
    end
endmodule

//--- testbench/adcsq_test.sv
// self-checking bench for the converter sequencing and sync control block
`timescale 1ns/1ps
module adcsq_test;
    import adcsq_pkg::*;
    logic i_clock, i_rst_n, i_clk_en, fire, wr, rd, strobe, odd, invalid, trig;
    logic [NUM_CONV*RAW_W-1:0] raw, raw_v;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, d;
    logic [NUM_CONV*SEL_W-1:0] sel;
    logic [3:0] frame, lf;
    logic [15:0] pattern, valid, good;
    logic [NUM_CONV*WORD_W-1:0] words;
    logic lo, ls;
    int num_errors, n_compared, seed, n;
    logic [1:0] res_tab [4] = '{2'h3, RES_12, RES_14, RES_14};
    logic [1:0] mode_tab [4] = '{2'h3, MODE_16, MODE_16, MODE_8};

    adcsq_top i_adcsq_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
        .i_sync_trigger(trig), .i_conversion_word(raw), .i_addr(addr), .i_wr_data(wr_data),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .o_conv_strobe(strobe), .o_odd_sample(odd),
        .o_input_select(sel), .o_frame_phase(frame), .o_test_pattern(pattern),
        .o_data_invalid(invalid), .o_processed_word(words), .o_word_valid(valid));
    adcsq_host_model i_adcsq_host_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_fire(fire),
        .i_data_invalid(invalid), .i_word_valid(valid[0]), .o_sync_trigger(trig), .o_good_count(good));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    //------------------------------------------------------------
    // compare, report and expectation helpers
    //------------------------------------------------------------
    task automatic stop_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t port got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        addr <= a;
        wr_data <= v;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        @(negedge i_clock);
        v = rd_data;
    endtask
    task automatic fire_trig;
        @(posedge i_clock);
        fire <= 1'b1;
        @(posedge i_clock);
        fire <= 1'b0;
    endtask
    task automatic new_raw;
        for (int k = 0; k < NUM_CONV; k++) begin
            raw_v[k*RAW_W+:RAW_W] = RAW_W'($random(seed));
        end
        raw <= raw_v;
    endtask
    task automatic chk_lanes(input logic [1:0] r, input logic [1:0] m);
        for (int k = 0; k < NUM_CONV; k++) begin
            chk_out(words[k*WORD_W+:WORD_W], exp_fmt(raw_v[k*RAW_W+:RAW_W], r, m));
        end
    endtask
    function automatic logic [31:0] ctrl(input logic [1:0] r, input logic [1:0] m, input logic b, input logic k);
        return {25'h0, 1'b0, k, b, m, r};
    endfunction
    function automatic logic [4:0] exp_sel(input logic [1:0] m, input logic o, input int k);
        if (m == MODE_32) return o ? 5'(2 * k) : 5'(2 * k + 1);
        if (m == MODE_8) return 5'(k / 2);
        return 5'(k);
    endfunction
    function automatic logic [15:0] exp_fmt(input logic [13:0] r, input logic [1:0] res, input logic [1:0] m);
        if (m == MODE_8 || res == RES_10 || res == 2'h3) return {r[9:0], 6'h0};
        if (res == RES_12) return {r[11:0], 4'h0};
        return {r, 2'h0};
    endfunction

    //------------------------------------------------------------
    // trigger phase reset and sampling order for one input mode
    //------------------------------------------------------------
    task automatic run_mode(input logic [1:0] m);
        reg_wr(ADDR_CTRL, ctrl(RES_10, m, 1'b1, 1'b0));
        fire_trig();
        n = 0;
        while (invalid !== 1'b1 && n < 12) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 12) begin
            num_errors++;
            stop_test();
        end
        chk_out(odd, 1);
        chk_out(strobe, 1);
        chk_out(frame, 0);
        chk_out(pattern, 0);
        n = 0;
        while (invalid === 1'b1 && n < 12) begin
            @(negedge i_clock);
            n++;
            if (n == 1) begin
                chk_out(pattern, 1);
                chk_out(strobe, m != MODE_8);
                chk_out(odd, m == MODE_8);
            end
        end
        chk_out(n, 6);
        if (strobe !== 1'b1) @(negedge i_clock);
        lo = odd;
        lf = frame;
        ls = 1'b1;
        repeat (8) begin
            @(negedge i_clock);
            chk_out(strobe, (m == MODE_8) ? !ls : 1'b1);
            ls = strobe;
            if (strobe === 1'b1) begin
                chk_out(odd, !lo);
                chk_out(frame, 4'(lf + 4'h1));
                lo = odd;
                lf = frame;
            end
            for (int k = 0; k < NUM_CONV; k++) begin
                chk_out(sel[k*SEL_W+:SEL_W], exp_sel(m, odd, k));
            end
        end
    endtask

    initial begin
        seed = 89;
        i_rst_n = 1'b0;
        i_clk_en = 1'b1;
        fire = 1'b0;
        raw = '0;
        raw_v = '0;
        addr = '0;
        wr_data = '0;
        wr = 1'b0;
        rd = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        @(negedge i_clock);
        chk_out(strobe, 1);
        chk_out(sel[SEL_W*3+:SEL_W], 5'h3);
        reg_rd(ADDR_CTRL, d);
        chk_reg(d, 32'h0);
        reg_wr(8'h08, 32'hFFFF_FFFF);
        reg_rd(8'h08, d);
        chk_reg(d, 32'h0);
        reg_wr(ADDR_CTRL, 32'hFFFF_FFD5);
        reg_rd(ADDR_CTRL, d);
        chk_reg(d, 32'h55);
        run_mode(MODE_16);
        run_mode(MODE_32);
        run_mode(MODE_8);
        // masked trigger must leave all phases running
        reg_wr(ADDR_STATUS, 32'h1);
        reg_wr(ADDR_CTRL, ctrl(RES_10, MODE_16, 1'b1, 1'b1));
        fire_trig();
        @(negedge i_clock);
        lf = frame;
        repeat (12) begin
            @(negedge i_clock);
            chk_out(invalid, 0);
            chk_out(frame, 4'(lf + 4'h1));
            lf = frame;
        end
        reg_rd(ADDR_STATUS, d);
        chk_reg(d[0], 1);
        reg_wr(ADDR_STATUS, 32'h1);
        reg_rd(ADDR_STATUS, d);
        chk_reg(d[0], 0);
        // word formatting; all four table entries, none of them RES_10, run at half rate to stay within limits
        for (int i = 0; i < 4; i++) begin
            reg_wr(ADDR_CTRL, ctrl(res_tab[i], mode_tab[i], 1'b1, 1'b0));
            @(posedge i_clock);
            new_raw();
            repeat (8) begin
                @(posedge i_clock);
                i_clk_en <= (res_tab[i] == RES_10) ? 1'b1 : ~i_clk_en;
            end
            @(posedge i_clock);
            i_clk_en <= 1'b1;
            @(negedge i_clock);
            chk_lanes(res_tab[i], mode_tab[i]);
        end
        reg_wr(ADDR_CTRL, ctrl(RES_10, MODE_16, 1'b1, 1'b0));
        repeat (3) begin
            @(posedge i_clock);
            new_raw();
            @(posedge i_clock);
            @(negedge i_clock);
            chk_lanes(RES_10, MODE_16);
            chk_out(valid, 16'hFFFF);
        end
        @(posedge i_clock);
        i_clk_en <= 1'b0;
        @(negedge i_clock);
        lf = frame;
        d = pattern;
        repeat (3) @(negedge i_clock);
        chk_out(pattern, d[15:0]);
        chk_out(frame, lf);
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        chk_out(good != 16'h0, 1);
        stop_test();
    end
endmodule
